// ==== phy_ctrl_pkg.sv ====
package phy_ctrl_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [4:0]  CTRL_ADDR  = 5'h00;
    localparam logic [15:0] CTRL_RESET = 16'h3080;

    // ****************************************************************
    // field positions of the control register
    // ****************************************************************
    localparam int B_RESET    = 15;
    localparam int B_LOOP     = 14;
    localparam int B_SPEED    = 13;
    localparam int B_AN_EN    = 12;
    localparam int B_PDN      = 11;
    localparam int B_ISOLATE  = 10;
    localparam int B_RESTART  = 9;
    localparam int B_DUPLEX   = 8;
    localparam int B_COLTEST  = 7;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS   = 8;
    localparam int DEAD_TIME_NS    = 560;
    localparam int DEAD_CYCLES_RAW = DEAD_TIME_NS / CLK_PERIOD_NS;
    localparam int DEAD_CYCLES     = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
    localparam int TIMER_W         = 16;

endpackage

// ==== span_timer.sv ====
`timescale 1ns/1ns
module span_timer #(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         start,
    input  wire logic [W-1:0] length,
    output logic              busy,
    output logic              done
);

    // elaboration check: a one-bit counter cannot tell the last cycle from idle
    if (W < 2) begin : g_bad_width
        $error("span_timer width too small");
    end

    logic [W-1:0] cnt;
    wire          last = (cnt == {{(W-1){1'b0}}, 1'b1});

    // counts length cycles of busy, then one cycle of done
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            cnt  <= length;
            busy <= 1'b1;
            done <= 1'b0;
        end else begin
            done <= busy && last;
            busy <= busy && !last;
            cnt  <= busy ? cnt - 1'b1 : '0;
        end
    end

endmodule

// ==== phy_basic_control.sv ====
`timescale 1ns/1ns
module phy_basic_control
    import phy_ctrl_pkg::*;
#(
    parameter int RESET_CYCLES = 16
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_ready,
    input  wire logic        link_power_down,
    input  wire logic        mdi_loop_req,
    input  wire logic        an_speed_100,
    input  wire logic        an_full_duplex,
    input  wire logic [3:0]  tx_nibble,
    input  wire logic        tx_en,
    input  wire logic [3:0]  net_rx_nibble,
    input  wire logic        net_rx_dv,
    output logic      [3:0]  rx_nibble,
    output logic             rx_dv,
    output logic      [3:0]  net_tx_nibble,
    output logic             net_tx_en,
    output logic             rx_dead,
    output logic             soft_reset,
    output logic             an_restart,
    output logic             an_enable,
    output logic             speed_100,
    output logic             full_duplex,
    output logic             power_down,
    output logic             isolated,
    output logic             mii_loop,
    output logic             mdi_loop
);

    import phy_ctrl_pkg::*;

    // elaboration check: the reset span must fit the shared timer width
    if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << TIMER_W)) begin : g_bad_reset_cycles
        $error("RESET_CYCLES out of range");
    end

    // ****************************************************************
    // control bits
    // ****************************************************************
    logic loop;
    logic spd;
    logic an_en;
    logic pdn;
    logic iso;
    logic dup;
    logic coltest;
    logic restart;
    logic srst_busy;
    logic srst_done;
    logic dead_busy;

    // decode: writes are refused while the soft reset is still running
    wire addr_hit   = (reg_addr == CTRL_ADDR);
    wire wr_ok      = reg_wr && reg_ready && addr_hit && !srst_busy;
    wire srst_start = wr_ok && reg_wdata[B_RESET];
    wire loop_rise  = wr_ok && !srst_start && reg_wdata[B_LOOP] && !loop;

    // read image; duplex forced to one under negotiation
    wire [15:0] read_val = {srst_busy, loop, spd, an_en, pdn, iso, restart,
                            an_en | dup, coltest, 7'h00};

    // effective modes, before the output flops
    wire next_speed = an_en ? an_speed_100 : spd;
    wire next_dup   = loop ? 1'b1 : (an_en ? an_full_duplex : dup);

    // soft reset lasts RESET_CYCLES; bit 15 stays high until done
    span_timer #(.W(TIMER_W)) u_srst (
        .core_clk (core_clk),
        .nrst     (nrst),
        .start    (srst_start),
        .length   (TIMER_W'(RESET_CYCLES)),
        .busy     (srst_busy),
        .done     (srst_done)
    );

    // descrambler resync window on entering loopback
    span_timer #(.W(TIMER_W)) u_dead (
        .core_clk (core_clk),
        .nrst     (nrst),
        .start    (loop_rise),
        .length   (TIMER_W'(DEAD_CYCLES)),
        .busy     (dead_busy),
        .done     ()
    );

    // ****************************************************************
    // register storage
    // ****************************************************************
    // reset write reloads defaults at once so the link sees them during reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            {loop, spd, an_en, pdn, iso} <= CTRL_RESET[B_LOOP:B_ISOLATE];
            dup     <= CTRL_RESET[B_DUPLEX];
            coltest <= CTRL_RESET[B_COLTEST];
            restart <= 1'b0;
        end else if (srst_start) begin
            {loop, spd, an_en, pdn, iso} <= CTRL_RESET[B_LOOP:B_ISOLATE];
            dup     <= CTRL_RESET[B_DUPLEX];
            coltest <= CTRL_RESET[B_COLTEST];
            restart <= 1'b0;
        end else if (wr_ok) begin
            {loop, spd, an_en, pdn, iso} <= reg_wdata[B_LOOP:B_ISOLATE];
            dup     <= an_en ? dup : reg_wdata[B_DUPLEX];
            coltest <= reg_wdata[B_COLTEST];
            restart <= reg_wdata[B_RESTART];
        end else begin
            restart <= 1'b0;
        end
    end

    // bus answer and readiness
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
            reg_ready <= 1'b1;
        end else begin
            if (reg_rd) reg_rdata <= addr_hit ? read_val : 16'h0000;
            if (srst_start) reg_ready <= 1'b0;
            else if (srst_done) reg_ready <= 1'b1;
        end
    end

    // ****************************************************************
    // mode outputs and nibble path
    // ****************************************************************
    // all outputs are flopped; loopback data lags tx by one cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_nibble     <= 4'h0;
            rx_dv         <= 1'b0;
            net_tx_nibble <= 4'h0;
            net_tx_en     <= 1'b0;
            rx_dead       <= 1'b0;
            soft_reset    <= 1'b0;
            an_restart    <= 1'b0;
            an_enable     <= 1'b1;
            speed_100     <= 1'b1;
            full_duplex   <= 1'b0;
            power_down    <= 1'b0;
            isolated      <= 1'b0;
            mii_loop      <= 1'b0;
            mdi_loop      <= 1'b0;
        end else begin
            if (iso || (loop && dead_busy)) begin
                rx_nibble <= 4'h0;
                rx_dv     <= 1'b0;
            end else if (loop) begin
                rx_nibble <= tx_nibble;
                rx_dv     <= tx_en;
            end else begin
                rx_nibble <= net_rx_nibble;
                rx_dv     <= net_rx_dv;
            end
            // network side sees nothing while looped or isolated
            net_tx_nibble <= (iso || loop) ? 4'h0 : tx_nibble;
            net_tx_en     <= !(iso || loop) && tx_en;
            // dead flag covers the blanked loopback dead-window cycles, no extra lead cycle, but not the soft reset write cycle
            rx_dead       <= !srst_start && loop && dead_busy;
            soft_reset    <= srst_start || (srst_busy && !srst_done);
            an_restart    <= wr_ok && !srst_start && reg_wdata[B_RESTART];
            an_enable     <= an_en;
            speed_100     <= next_speed;
            full_duplex   <= next_dup;
            power_down    <= pdn || link_power_down;
            isolated      <= iso;
            mii_loop      <= loop;
            mdi_loop      <= mdi_loop_req && !loop;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_SRST_BUSY: assert property (srst_start |=> !reg_ready && soft_reset && spd && an_en && !loop)
        else $error("soft reset did not load defaults");
    AST_SRST_READ: assert property ((reg_rd && addr_hit && srst_busy) |=> reg_rdata[B_RESET])
        else $error("reset bit read zero during reset");
    AST_SRST_END: assert property ($rose(reg_ready) |-> !srst_busy && !soft_reset && coltest)
        else $error("ready returned before reset end");
    AST_LOOP_DATA: assert property ((loop && !iso && !dead_busy) |=> rx_nibble == $past(tx_nibble))
        else $error("loopback nibble mismatch");
    AST_DEAD: assert property (loop_rise |=> ##1 (rx_dead || !mii_loop || soft_reset) [*8])
        else $error("dead time too short");
    AST_LOOP_PREC: assert property (loop |=> !mdi_loop)
        else $error("medium loopback not overridden");
    AST_SPEED: assert property (!an_en |=> speed_100 == $past(spd))
        else $error("forced speed not applied");
    AST_DUP_READ: assert property ((reg_rd && addr_hit && an_en) |=> reg_rdata[B_DUPLEX])
        else $error("duplex not one under negotiation");
    AST_PDN: assert property ((pdn || link_power_down) |=> power_down)
        else $error("power down not ORed");
    AST_ISO: assert property (iso |=> !rx_dv && !net_tx_en)
        else $error("isolate leaked data");
    AST_RESTART: assert property ((wr_ok && !srst_start && reg_wdata[B_RESTART]) |=> an_restart ##1 !restart)
        else $error("restart bit did not self-clear");

    COV_SRST: cover property (srst_start ##[1:300] reg_ready);
    COV_LOOP: cover property (loop_rise ##[1:100] (rx_dv && !rx_dead));
    COV_RESTART: cover property (an_restart);
    COV_FORCED: cover property (!an_en && !speed_100 && full_duplex);

endmodule

// ==== mac_model.sv ====
`timescale 1ns/1ns
// ****************************************************************
// management frame source standing in for the host controller
// ****************************************************************
module mac_model (
    input  wire logic        core_clk,
    input  wire logic        reg_ready,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [4:0]  reg_addr,
    output logic      [15:0] reg_wdata
);
    // idle bus at time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 5'h1F;
        reg_wdata = 16'hFFFF;
    end

    // entered just after a falling edge; the strobe spans one rising edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input bit hold);
        int n;
        n = 0;
        // a careful host waits out a soft reset; hold=0 is the rude host
        while (hold && reg_ready !== 1'b1 && n < 64) begin
            @(negedge core_clk);
            n++;
        end
        reg_addr  = a;
        reg_wdata = d & 16'hFF80;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~reg_wdata; // stale data must not look valid
    endtask

    // reads are not held off, so reset progress can be observed
    task automatic rd(input logic [4:0] a);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd   = 1'b0;
    endtask
endmodule

// ==== test_phy_basic_control.sv ====
`timescale 1ns/1ns
module test_phy_basic_control;
    import phy_ctrl_pkg::*;
    localparam int RC = 4;
    logic core_clk, nrst, reg_wr, reg_rd, reg_ready, link_power_down, mdi_loop_req, an_speed_100, an_full_duplex;
    logic tx_en, net_rx_dv, rx_dv, net_tx_en, rx_dead, soft_reset, an_restart, an_enable, speed_100, full_duplex;
    logic power_down, isolated, mii_loop, mdi_loop, rd_d;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [3:0]  tx_nibble, net_rx_nibble, rx_nibble, net_tx_nibble;
    logic [15:0] exp_q[$];
    int          n_errors, n_compared, n, i;

    phy_basic_control #(.RESET_CYCLES(RC)) dut (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ready(reg_ready),
        .link_power_down(link_power_down), .mdi_loop_req(mdi_loop_req), .an_speed_100(an_speed_100),
        .an_full_duplex(an_full_duplex), .tx_nibble(tx_nibble), .tx_en(tx_en), .net_rx_nibble(net_rx_nibble),
        .net_rx_dv(net_rx_dv), .rx_nibble(rx_nibble), .rx_dv(rx_dv), .net_tx_nibble(net_tx_nibble),
        .net_tx_en(net_tx_en), .rx_dead(rx_dead), .soft_reset(soft_reset), .an_restart(an_restart),
        .an_enable(an_enable), .speed_100(speed_100), .full_duplex(full_duplex), .power_down(power_down),
        .isolated(isolated), .mii_loop(mii_loop), .mdi_loop(mdi_loop));
    mac_model mac (.core_clk(core_clk), .reg_ready(reg_ready), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // note the expected word, then let the host model issue the read
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        mac.rd(a);
    endtask
    // modes show one cycle after the write edge; three falls cover it
    task automatic settle;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic complete_run;
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // read monitor: answer is looked at in the cycle after the strobe
    // ****************************************************************
    always @(posedge core_clk) rd_d <= reg_rd;
    always @(negedge core_clk) begin
        if (rd_d === 1'b1)
            chk(reg_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD);
    end
    // random transmit and network traffic, from reset release to the end of the run
    always @(negedge core_clk) begin
        if (nrst === 1'b1) begin
            tx_nibble     <= 4'($urandom);
            tx_en         <= 1'($urandom);
            net_rx_nibble <= 4'($urandom);
            net_rx_dv     <= 1'($urandom);
        end
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(72158));
        {nrst, link_power_down, mdi_loop_req, tx_en, net_rx_dv, tx_nibble, net_rx_nibble} = '0;
        an_speed_100   = 1'($urandom);
        an_full_duplex = 1'($urandom);
        n_errors       = 0;
        n_compared     = 0;
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        chk(16'({an_enable, speed_100, full_duplex}), 16'h0006);
        rdc(CTRL_ADDR, 16'h3180);
        mac.wr(CTRL_ADDR, 16'h3280, 1'b1);
        chk(16'(an_restart), 16'h0001);
        @(negedge core_clk);
        chk(16'(an_restart), 16'h0000);
        rdc(CTRL_ADDR, 16'h3180);
        // forced speed and duplex, every combination, collision test cleared
        for (i = 0; i < 4; i++) begin
            mac.wr(CTRL_ADDR, 16'({i[1], 4'h0, i[0], 8'h00}), 1'b1);
            settle();
            chk(16'({speed_100, full_duplex}), 16'(i));
            rdc(CTRL_ADDR, 16'({i[1], 4'h0, i[0], 8'h00}));
        end
        mac.wr(CTRL_ADDR, 16'h1000, 1'b1);
        settle();
        chk(16'({speed_100, full_duplex}), 16'({an_speed_100, an_full_duplex}));
        rdc(CTRL_ADDR, 16'h1100);
        // low power from the register bit or the host link indication
        for (i = 0; i < 4; i++) begin
            link_power_down = i[1];
            mac.wr(CTRL_ADDR, 16'({i[0], 11'h000}), 1'b1);
            settle();
            chk(16'(power_down), 16'(i != 0));
            // neither looped nor isolated: both data paths pass straight through
            chk(16'({rx_nibble, rx_dv, net_tx_nibble, net_tx_en}),
                16'({net_rx_nibble, net_rx_dv, tx_nibble, tx_en}));
        end
        link_power_down = 1'b0;
        mac.wr(CTRL_ADDR, 16'h0400, 1'b1);
        settle();
        for (i = 0; i < 8; i++) begin
            chk(16'({isolated, net_tx_en, rx_dv}), 16'h0004);
            @(negedge core_clk);
        end
        // loopback with the medium-side request also raised
        mdi_loop_req = 1'b1;
        mac.wr(CTRL_ADDR, 16'h4000, 1'b1);
        @(negedge core_clk); // the dead window opens one edge after the write lands
        n = 0;
        while (rx_dead === 1'b1 && n < 200) begin
            if (rx_dv !== 1'b0)
                n = 500;
            n++;
            @(negedge core_clk);
        end
        chk(16'(n), 16'(DEAD_CYCLES));
        chk(16'({mii_loop, mdi_loop, full_duplex}), 16'h0005);
        for (i = 0; i < 8; i++) begin
            chk(16'({rx_nibble, rx_dv}), 16'({tx_nibble, tx_en}));
            chk(16'({net_tx_nibble, net_tx_en}), 16'h0000);
            @(negedge core_clk);
        end
        // an unmapped place reads zero and takes no write
        mac.wr(5'($urandom_range(31, 1)), 16'h0800, 1'b1);
        rdc(5'($urandom_range(31, 1)), 16'h0000);
        @(negedge core_clk); // let an edge pass so the read strobe drops between reads
        rdc(CTRL_ADDR, 16'h4000);
        // soft reset: defaults at once, reset bit reads one, writes refused
        mac.wr(CTRL_ADDR, 16'h8000, 1'b1);
        chk(16'({reg_ready, soft_reset}), 16'h0001);
        rdc(CTRL_ADDR, 16'hB180);
        mac.wr(CTRL_ADDR, 16'h0800, 1'b0);
        n = 2;
        while (reg_ready !== 1'b1 && n < 100) begin
            n++;
            @(negedge core_clk);
        end
        // ready comes back one edge after the timer's done pulse
        chk(16'(n), 16'(RC + 1));
        rdc(CTRL_ADDR, 16'h3180);
        settle();
        chk(16'({mii_loop, mdi_loop, power_down, soft_reset}), 16'h0004);
        chk(16'(exp_q.size()), 16'h0000);
        complete_run();
    end
endmodule
